//--- inc/fwp_pkg.sv
// Package of constants and types for the flash write protection block.
// How it works
// [R01] A program or erase aimed at a block that the protect code marks is refused.
// [R02] A full-array erase runs only when all four protect-select bits are zero.
// [R03] Protect code 0000/1111 guard nothing, 0001 block 3, 0010 blocks 2-3, 0111/1000 all, 1101 blocks 0-1, 1110 block 0.
// [R04] Every protect code without a listed area guards all blocks.
// [R05] With status-write-disable set and the protect pin low, a status write is ignored.
// [R06] A status write is taken when status-write-disable is clear, or when it is set and the protect pin is high.
// [R07] The protect pin guards the protect-select, status-write-disable and quad-enable bits.
// [R08] Quad-enable clear keeps the protect and pause pins as controls; set turns them into data lines 2 and 3.
// [R09] The host keeps quad-enable clear where the protect or pause pin is tied to the supply.
// [R10] The suspend-state register has erase-suspended at bit 1 and program-suspended at bit 2, others zero, read-only.
// [R11] A suspend during an erase sets erase-suspended; the resume of that erase clears it.
// [R12] A suspend during a program sets program-suspended; the resume of that program clears it.
// [R13] Program, erase and status writes are ignored unless the write latch is set.
// [R14] Protect-select and status-write-disable change only by a status write and start at zero.
// [R15] The write latch clears itself when a write, program or erase completes.
package fwp_pkg;

    // Status register layout
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_LATCH_BIT = 1;
    localparam int STAT_SEL_LSB   = 2;
    localparam int STAT_SEL_MSB   = 5;
    localparam int STAT_QUAD_BIT  = 6;
    localparam int STAT_SWD_BIT   = 7;
    localparam logic [7:0] STAT_RESET = 8'h00;

    // Suspend-state register layout
    localparam int SUSP_ERASE_BIT = 1;
    localparam int SUSP_PROG_BIT  = 2;
    localparam logic [7:0] SUSP_RESET = 8'h00;

    // Array geometry: 64 Kbyte blocks, block index from address bits 17:16
    localparam int ADDR_W      = 24;
    localparam int BLOCK_LSB   = 16;
    localparam int BLOCK_MSB   = 17;
    localparam int BLOCK_COUNT = 4;

    // Protect-select codes with a listed area
    localparam logic [3:0] SEL_NONE_LO  = 4'h0;
    localparam logic [3:0] SEL_TOP1     = 4'h1;
    localparam logic [3:0] SEL_TOP2     = 4'h2;
    localparam logic [3:0] SEL_ALL_LO   = 4'h7;
    localparam logic [3:0] SEL_ALL_HI   = 4'h8;
    localparam logic [3:0] SEL_BOT2     = 4'hD;
    localparam logic [3:0] SEL_BOT1     = 4'hE;
    localparam logic [3:0] SEL_NONE_HI  = 4'hF;

    // Block masks, bit n guards block n
    localparam logic [3:0] MASK_NONE = 4'h0;
    localparam logic [3:0] MASK_TOP1 = 4'h8;
    localparam logic [3:0] MASK_TOP2 = 4'hC;
    localparam logic [3:0] MASK_BOT2 = 4'h3;
    localparam logic [3:0] MASK_BOT1 = 4'h1;
    localparam logic [3:0] MASK_ALL  = 4'hF;

    // Operation handed to the array engine
    typedef enum logic [1:0] {
        FWP_OP_PROGRAM,
        FWP_OP_ERASE,
        FWP_OP_CHIP_ERASE,
        FWP_OP_STATUS
    } fwp_op_t;

    // Write-cycle state
    typedef enum logic [2:0] {
        FWP_IDLE,
        FWP_PROGRAM,
        FWP_ERASE,
        FWP_PROG_SUSP,
        FWP_ERASE_SUSP,
        FWP_STATUS_WR
    } fwp_state_t;

endpackage

//--- hw/fwp_protect_decode.sv
// Protect-select code to per-block guard mask.
`timescale 1ns/1ps
module fwp_protect_decode (
    input  wire logic [3:0] protectSel,
    output logic      [3:0] blockMask
);

    // Listed codes map to their area, the rest fall back to all blocks
    function automatic logic [3:0] selToMask(input logic [3:0] sel);
        logic [3:0] m;
        m = fwp_pkg::MASK_ALL;
        case (sel)
            // [R03] listed areas
            fwp_pkg::SEL_NONE_LO: m = fwp_pkg::MASK_NONE;
            fwp_pkg::SEL_NONE_HI: m = fwp_pkg::MASK_NONE;
            fwp_pkg::SEL_TOP1:    m = fwp_pkg::MASK_TOP1;
            fwp_pkg::SEL_TOP2:    m = fwp_pkg::MASK_TOP2;
            fwp_pkg::SEL_ALL_LO:  m = fwp_pkg::MASK_ALL;
            fwp_pkg::SEL_ALL_HI:  m = fwp_pkg::MASK_ALL;
            fwp_pkg::SEL_BOT2:    m = fwp_pkg::MASK_BOT2;
            fwp_pkg::SEL_BOT1:    m = fwp_pkg::MASK_BOT1;
            // [R04] unlisted codes guard all
            default:              m = fwp_pkg::MASK_ALL;
        endcase
        return m;
    endfunction

    // Pure decode, no state
    assign blockMask = selToMask(protectSel);

endmodule

//--- hw/flash_write_protection.sv
// Write protection, status and suspend-state logic of the serial flash.
`timescale 1ns/1ps
module flash_write_protection (
    input  wire logic                        mclk,
    input  wire logic                        nrst,
    // Decoded instruction strobes, one cycle each
    input  wire logic                        cmdSetLatch,
    input  wire logic                        cmdClearLatch,
    input  wire logic                        cmdStatusWrite,
    input  wire logic [7:0]                  statusWriteData,
    input  wire logic                        cmdProgram,
    input  wire logic                        cmdErase,
    input  wire logic                        cmdFullArrayErase,
    input  wire logic [fwp_pkg::ADDR_W-1:0]  cmdAddr,
    input  wire logic                        cmdSuspend,
    input  wire logic                        cmdResume,
    // Array engine handshake
    input  wire logic                        arrayDone,
    output logic                             arrayStart,
    output logic [1:0]                       arrayOp,
    output logic [fwp_pkg::ADDR_W-1:0]       arrayAddr,
    output logic                             arrayPause,
    // Outcome of each write-type instruction
    output logic                             cmdTaken,
    output logic                             cmdIgnored,
    // Register contents as read out by the serial path
    output logic [7:0]                       statusReg,
    output logic [7:0]                       suspendState,
    // Protect pin / data line 2
    input  wire logic                        dataLine2In,
    output logic                             dataLine2Out,
    output logic                             dataLine2OeN,
    // Pause pin / data line 3
    input  wire logic                        dataLine3In,
    output logic                             dataLine3Out,
    output logic                             dataLine3OeN,
    // Quad data path side
    input  wire logic                        quadDrive,
    input  wire logic [1:0]                  quadDataOut,
    output logic [1:0]                       quadDataIn,
    output logic                             quadMode,
    output logic                             serialPaused
);

    // Non-volatile cells and volatile flags
    logic [3:0]           protectSel_r;
    logic [3:0]           protectSel_nxt;
    logic                 statusWriteDisable_r;
    logic                 statusWriteDisable_nxt;
    logic                 quadEnable_r;
    logic                 quadEnable_nxt;
    logic                 writeLatch_r;
    logic                 writeLatch_nxt;
    logic                 eraseSusp_r;
    logic                 eraseSusp_nxt;
    logic                 progSusp_r;
    logic                 progSusp_nxt;
    logic [7:0]           pendStatus_r;
    logic [7:0]           pendStatus_nxt;

    fwp_pkg::fwp_state_t  state_r;
    fwp_pkg::fwp_state_t  state_nxt;

    // Outputs held in flip-flops
    logic                 arrayStart_nxt;
    logic [1:0]           arrayOp_nxt;
    logic [fwp_pkg::ADDR_W-1:0] arrayAddr_nxt;
    logic                 cmdTaken_nxt;
    logic                 cmdIgnored_nxt;

    // Pin synchronisers, first stage read only by the second
    logic [1:0]           wpMeta_r;
    logic [1:0]           wpSync_r;

    // Decode wires
    logic [3:0]           blockMask;
    logic [1:0]           targetBlock;
    logic                 targetGuarded;
    logic                 anySelSet;
    logic                 protectPinLow;
    logic                 statusLocked;
    logic                 idle;
    logic                 progOk;
    logic                 eraseOk;
    logic                 fullEraseOk;
    logic                 statusOk;
    logic                 writeCmd;
    logic                 opStarts;
    logic                 cycleEnds;

    fwp_protect_decode u_decode (
        .protectSel (protectSel_r),
        .blockMask  (blockMask)
    );

    // Both pins cross in through two flops before any use
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wpMeta_r <= 2'h3;
            wpSync_r <= 2'h3;
        end else begin
            wpMeta_r <= {dataLine3In, dataLine2In};
            wpSync_r <= wpMeta_r;
        end
    end

    // [R08] pins as controls or as data lines
    assign quadMode     = quadEnable_r;
    assign quadDataIn   = wpSync_r;
    assign dataLine2Out = quadDataOut[0];
    assign dataLine3Out = quadDataOut[1];
    assign dataLine2OeN = ~(quadEnable_r & quadDrive);
    assign dataLine3OeN = ~(quadEnable_r & quadDrive);
    assign serialPaused = ~quadEnable_r & ~wpSync_r[1];

    // A quad part has no protect pin, so it never counts as low
    assign protectPinLow = ~quadEnable_r & ~wpSync_r[0];

    // [R05] status register lock
    assign statusLocked  = statusWriteDisable_r & protectPinLow;

    // [R01] target block check
    assign targetBlock   = cmdAddr[fwp_pkg::BLOCK_MSB:fwp_pkg::BLOCK_LSB];
    assign targetGuarded = blockMask[targetBlock];
    assign anySelSet     = |protectSel_r;
    assign idle          = (state_r == fwp_pkg::FWP_IDLE);

    // [R13] nothing writes without the latch
    assign progOk      = cmdProgram & idle & writeLatch_r & ~targetGuarded;
    assign eraseOk     = cmdErase & idle & writeLatch_r & ~targetGuarded;
    // [R02] full-array erase only with all select bits clear
    assign fullEraseOk = cmdFullArrayErase & idle & writeLatch_r & ~anySelSet;
    // [R06] status write accepted when unlocked
    assign statusOk    = cmdStatusWrite & idle & writeLatch_r & ~statusLocked;

    assign writeCmd  = cmdProgram | cmdErase | cmdFullArrayErase | cmdStatusWrite;
    assign opStarts  = progOk | eraseOk | fullEraseOk | statusOk;
    // Status writes finish on their own after one cycle
    assign cycleEnds = (state_r == fwp_pkg::FWP_STATUS_WR) ||
                       (arrayDone && (state_r == fwp_pkg::FWP_PROGRAM || state_r == fwp_pkg::FWP_ERASE));

    // Write-cycle sequencing and suspend flags
    always_comb begin
        state_nxt      = state_r;
        eraseSusp_nxt  = eraseSusp_r;
        progSusp_nxt   = progSusp_r;
        pendStatus_nxt = pendStatus_r;
        arrayStart_nxt = 1'b0;
        arrayOp_nxt    = arrayOp;
        arrayAddr_nxt  = arrayAddr;
        case (state_r)
            fwp_pkg::FWP_IDLE: begin
                if (progOk) begin
                    state_nxt      = fwp_pkg::FWP_PROGRAM;
                    arrayStart_nxt = 1'b1;
                    arrayOp_nxt    = fwp_pkg::FWP_OP_PROGRAM;
                    arrayAddr_nxt  = cmdAddr;
                end else if (eraseOk || fullEraseOk) begin
                    state_nxt      = fwp_pkg::FWP_ERASE;
                    arrayStart_nxt = 1'b1;
                    arrayOp_nxt    = eraseOk ? fwp_pkg::FWP_OP_ERASE : fwp_pkg::FWP_OP_CHIP_ERASE;
                    arrayAddr_nxt  = cmdAddr;
                end else if (statusOk) begin
                    state_nxt      = fwp_pkg::FWP_STATUS_WR;
                    arrayOp_nxt    = fwp_pkg::FWP_OP_STATUS;
                    pendStatus_nxt = statusWriteData;
                end
            end
            fwp_pkg::FWP_PROGRAM: begin
                if (arrayDone) begin
                    state_nxt = fwp_pkg::FWP_IDLE;
                end else if (cmdSuspend) begin
                    // [R12] program suspended
                    state_nxt    = fwp_pkg::FWP_PROG_SUSP;
                    progSusp_nxt = 1'b1;
                end
            end
            fwp_pkg::FWP_ERASE: begin
                if (arrayDone) begin
                    state_nxt = fwp_pkg::FWP_IDLE;
                end else if (cmdSuspend) begin
                    // [R11] erase suspended
                    state_nxt     = fwp_pkg::FWP_ERASE_SUSP;
                    eraseSusp_nxt = 1'b1;
                end
            end
            fwp_pkg::FWP_PROG_SUSP: begin
                if (cmdResume) begin
                    // [R12] program resumes
                    state_nxt    = fwp_pkg::FWP_PROGRAM;
                    progSusp_nxt = 1'b0;
                end
            end
            fwp_pkg::FWP_ERASE_SUSP: begin
                if (cmdResume) begin
                    // [R11] erase resumes
                    state_nxt     = fwp_pkg::FWP_ERASE;
                    eraseSusp_nxt = 1'b0;
                end
            end
            fwp_pkg::FWP_STATUS_WR: begin
                state_nxt = fwp_pkg::FWP_IDLE;
            end
            default: begin
                state_nxt = fwp_pkg::FWP_IDLE;
            end
        endcase
    end

    // Protection cells change only when a status write commits
    always_comb begin
        protectSel_nxt         = protectSel_r;
        statusWriteDisable_nxt = statusWriteDisable_r;
        quadEnable_nxt         = quadEnable_r;
        if (state_r == fwp_pkg::FWP_STATUS_WR) begin
            // [R14] status write alone updates the cells
            protectSel_nxt         = pendStatus_r[fwp_pkg::STAT_SEL_MSB:fwp_pkg::STAT_SEL_LSB];
            statusWriteDisable_nxt = pendStatus_r[fwp_pkg::STAT_SWD_BIT];
            quadEnable_nxt         = pendStatus_r[fwp_pkg::STAT_QUAD_BIT];
        end
    end

    // Write latch: set beats the automatic clear at cycle end
    always_comb begin
        writeLatch_nxt = writeLatch_r;
        // [R15] cleared on completion
        if (cycleEnds || cmdClearLatch) begin
            writeLatch_nxt = 1'b0;
        end
        if (cmdSetLatch) begin
            writeLatch_nxt = 1'b1;
        end
    end

    // Outcome pulses; a write while busy or suspended is ignored
    // [R07] locked status writes show up as ignored
    assign cmdTaken_nxt   = opStarts;
    assign cmdIgnored_nxt = writeCmd & ~opStarts;

    // State registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r <= fwp_pkg::FWP_IDLE;
            pendStatus_r <= fwp_pkg::STAT_RESET;
        end else begin
            state_r <= state_nxt;
            pendStatus_r <= pendStatus_nxt;
        end
    end

    // Cells start at their factory value of zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            protectSel_r         <= 4'h0;
            statusWriteDisable_r <= 1'b0;
            quadEnable_r         <= 1'b0;
        end else begin
            protectSel_r         <= protectSel_nxt;
            statusWriteDisable_r <= statusWriteDisable_nxt;
            quadEnable_r         <= quadEnable_nxt;
        end
    end

    // Volatile flags clear at reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            writeLatch_r <= 1'b0;
            eraseSusp_r  <= 1'b0;
            progSusp_r   <= 1'b0;
        end else begin
            writeLatch_r <= writeLatch_nxt;
            eraseSusp_r  <= eraseSusp_nxt;
            progSusp_r   <= progSusp_nxt;
        end
    end

    // Registered handshake toward the array engine
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            arrayStart <= 1'b0;
            arrayOp    <= 2'h0;
            arrayAddr  <= 24'h00_0000;
            cmdTaken   <= 1'b0;
            cmdIgnored <= 1'b0;
        end else begin
            arrayStart <= arrayStart_nxt;
            arrayOp    <= arrayOp_nxt;
            arrayAddr  <= arrayAddr_nxt;
            cmdTaken   <= cmdTaken_nxt;
            cmdIgnored <= cmdIgnored_nxt;
        end
    end

    // Engine holds while either suspend state stands
    assign arrayPause = (state_r == fwp_pkg::FWP_PROG_SUSP) || (state_r == fwp_pkg::FWP_ERASE_SUSP);

    // Read-back images
    always_comb begin
        statusReg = fwp_pkg::STAT_RESET;
        statusReg[fwp_pkg::STAT_BUSY_BIT]  = ~idle;
        statusReg[fwp_pkg::STAT_LATCH_BIT] = writeLatch_r;
        statusReg[fwp_pkg::STAT_SEL_MSB:fwp_pkg::STAT_SEL_LSB] = protectSel_r;
        statusReg[fwp_pkg::STAT_QUAD_BIT]  = quadEnable_r;
        statusReg[fwp_pkg::STAT_SWD_BIT]   = statusWriteDisable_r;
    end

    // [R10] reserved bits read zero
    always_comb begin
        suspendState = fwp_pkg::SUSP_RESET;
        suspendState[fwp_pkg::SUSP_ERASE_BIT] = eraseSusp_r;
        suspendState[fwp_pkg::SUSP_PROG_BIT]  = progSusp_r;
    end

endmodule

//--- dv/fwp_checker_asserts.sv
// Port-level assertions for the flash write protection block.
`timescale 1ns/1ps
module fwp_checker (
    input wire logic       mclk,
    input wire logic       nrst,
    input wire logic       cmdSetLatch,
    input wire logic       cmdStatusWrite,
    input wire logic       cmdProgram,
    input wire logic       cmdErase,
    input wire logic       cmdFullArrayErase,
    input wire logic       cmdSuspend,
    input wire logic       cmdResume,
    input wire logic       arrayDone,
    input wire logic [1:0] arrayOp,
    input wire logic       arrayPause,
    input wire logic       cmdTaken,
    input wire logic       cmdIgnored,
    input wire logic [7:0] statusReg,
    input wire logic [7:0] suspendState,
    input wire logic       dataLine2OeN,
    input wire logic       dataLine3OeN,
    input wire logic [1:0] quadDataIn,
    input wire logic       quadMode,
    input wire logic       serialPaused
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // Any write-type strobe, and the running-op test before a suspend
    sequence sWrite;
        cmdProgram || cmdErase || cmdFullArrayErase || cmdStatusWrite;
    endsequence
    sequence sRunning(logic [1:0] op);
        statusReg[0] && !arrayPause && !arrayDone && arrayOp == op;
    endsequence

    AST_ONE_ANSWER: assert property (sWrite |=> cmdTaken ^ cmdIgnored)
        else $error("write strobe without exactly one outcome");
    AST_NO_LATCH: assert property (sWrite ##0 !statusReg[1] |=> cmdIgnored)
        else $error("write taken with latch clear");
    AST_FULL_GUARD: assert property (cmdFullArrayErase && statusReg[5:2] != 4'h0 |=> cmdIgnored)
        else $error("full erase taken with protect bits set");
    AST_SW_LOCK: assert property (cmdStatusWrite && statusReg[7] && !statusReg[6] && !quadDataIn[0]
        |=> cmdIgnored ##1 $stable(statusReg[7:2])) else $error("locked status write taken");
    AST_SEL_SRC: assert property (statusReg[7:2] != $past(statusReg[7:2]) |-> $past(cmdStatusWrite, 2))
        else $error("protection bits changed without status write");
    AST_DONE_CLR: assert property (arrayDone && statusReg[0] && !arrayPause && !cmdSetLatch
        |=> !statusReg[0] && !statusReg[1]) else $error("latch or busy left after completion");
    AST_ERASE_SUSP: assert property (cmdSuspend ##0 sRunning(2'h1) |=> suspendState == 8'h02 && arrayPause)
        else $error("erase suspend flag not set");
    AST_PROG_SUSP: assert property (cmdSuspend ##0 sRunning(2'h0) |=> suspendState == 8'h04 && arrayPause)
        else $error("program suspend flag not set");
    AST_RESUME: assert property (cmdResume && arrayPause |=> suspendState == 8'h00 && !arrayPause)
        else $error("suspend flag not cleared on resume");
    AST_SUSP_RSVD: assert property (suspendState[7:3] == 5'h00 && !suspendState[0])
        else $error("reserved suspend bit set");
    AST_PIN_ROLE: assert property (!quadMode |-> dataLine2OeN && dataLine3OeN
        && serialPaused == !quadDataIn[1]) else $error("pin roles wrong with quad clear");
endmodule

bind flash_write_protection fwp_checker uChk (.mclk, .nrst, .cmdSetLatch, .cmdStatusWrite, .cmdProgram,
    .cmdErase, .cmdFullArrayErase, .cmdSuspend, .cmdResume, .arrayDone, .arrayOp, .arrayPause, .cmdTaken,
    .cmdIgnored, .statusReg, .suspendState, .dataLine2OeN, .dataLine3OeN, .quadDataIn, .quadMode, .serialPaused);

//--- dv/fwp_array_model.sv
// Array engine stand-in answering each started program or erase after a delay.
`timescale 1ns/1ps
module fwp_array_model (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       arrayStart,
    input  wire logic [1:0] arrayOp,
    input  wire logic       arrayPause,
    input  wire logic [7:0] doneDelay,
    output logic            arrayDone
);
    logic [7:0] cnt;
    logic       run;

    // Counts only while not paused; a suspended op makes no progress
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            run <= 1'b0;
            cnt <= 8'h00;
            arrayDone <= 1'b0;
        end else begin
            arrayDone <= 1'b0;
            if (arrayStart && arrayOp != 2'h3) begin
                run <= 1'b1;
                cnt <= 8'h00;
            end else if (run && !arrayPause) begin
                cnt <= cnt + 8'h01;
                if (cnt == doneDelay) begin
                    arrayDone <= 1'b1;
                    run <= 1'b0;
                end
            end
        end
    end
endmodule

//--- dv/flash_write_protection_bench.sv
// Self-checking bench: write strobes, protect codes, suspend and pin roles.
`timescale 1ns/1ps
module flash_write_protection_bench;
    logic                       mclk, nrst, cmdSuspend, cmdResume, quadDrive, pin2Drv, pin3Drv;
    logic [5:0]                 stb;
    wire logic                  cmdSetLatch, cmdClearLatch, cmdStatusWrite, cmdProgram, cmdErase, cmdFullArrayErase;
    logic                       arrayDone, arrayStart, arrayPause, cmdTaken, cmdIgnored, quadMode, serialPaused;
    logic                       dataLine2Out, dataLine2OeN, dataLine3Out, dataLine3OeN;
    logic [7:0]                 statusWriteData, statusReg, suspendState, doneDelay;
    logic [fwp_pkg::ADDR_W-1:0] cmdAddr, arrayAddr;
    logic [1:0]                 arrayOp, quadDataOut, quadDataIn;
    wire logic                  line2, line3;
    logic [3:0]                 m;
    int                         miscompares, testsRun;

    // Strobe vector: bit k is instruction kind k
    assign {cmdFullArrayErase, cmdErase, cmdProgram, cmdStatusWrite, cmdClearLatch, cmdSetLatch} = stb;
    // Pin level: device drives when its enable is low, else the bench side
    assign line2 = dataLine2OeN ? pin2Drv : dataLine2Out;
    assign line3 = dataLine3OeN ? pin3Drv : dataLine3Out;

    flash_write_protection uut (.mclk, .nrst, .cmdSetLatch, .cmdClearLatch, .cmdStatusWrite, .statusWriteData,
        .cmdProgram, .cmdErase, .cmdFullArrayErase, .cmdAddr, .cmdSuspend, .cmdResume, .arrayDone, .arrayStart,
        .arrayOp, .arrayAddr, .arrayPause, .cmdTaken, .cmdIgnored, .statusReg, .suspendState,
        .dataLine2In(line2), .dataLine2Out, .dataLine2OeN, .dataLine3In(line3), .dataLine3Out, .dataLine3OeN,
        .quadDrive, .quadDataOut, .quadDataIn, .quadMode, .serialPaused);
    fwp_array_model uEng (.mclk, .nrst, .arrayStart, .arrayOp, .arrayPause, .doneDelay, .arrayDone);

    task automatic tick(input int n = 1);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        testsRun++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finishTest();
        if (miscompares == 0 && testsRun > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Kinds: 0 set latch, 1 clear latch, 2 status write, 3 program, 4 erase, 5 full erase
    task automatic op(input int k, input logic [23:0] a, input logic [7:0] d, input logic expTaken);
        cmdAddr = a;
        statusWriteData = d;
        stb = 6'h01 << k;
        tick();
        stb = 6'h00;
        if (k >= 2) check({cmdTaken, cmdIgnored}, {expTaken, !expTaken});
        tick();
    endtask

    // Bounded wait for the busy bit to drop
    task automatic waitIdle();
        int i;
        for (i = 0; i < 300 && statusReg[0] !== 1'b0; i++) tick();
        if (i == 300) begin
            miscompares++;
            finishTest();
        end
    endtask

    task automatic setStatus(input logic [7:0] d);
        op(0, 24'h00_0000, 8'h00, 1'b1);
        op(2, 24'h00_0000, d, 1'b1);
        waitIdle();
        check(statusReg[7:2], d[7:2]);
        check(statusReg[1], 1'b0);
    endtask

    function automatic logic [3:0] maskOf(input logic [3:0] c);
        case (c)
            4'h0, 4'hF: return 4'h0;
            4'h1: return 4'h8;
            4'h2: return 4'hC;
            4'hD: return 4'h3;
            4'hE: return 4'h1;
            default: return 4'hF;
        endcase
    endfunction

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        nrst = 1'b0; stb = 6'h00; cmdAddr = 24'h00_0000; statusWriteData = 8'h00;
        cmdSuspend = 1'b0; cmdResume = 1'b0; quadDrive = 1'b0; quadDataOut = 2'h0;
        pin2Drv = 1'b1; pin3Drv = 1'b1; doneDelay = 8'h03; miscompares = 0; testsRun = 0;
        repeat (3) @(posedge mclk);
        #1 nrst = 1'b1;
        check(statusReg, 8'h00);
        check(suspendState, 8'h00);
        // Writes without the latch, and after clearing it
        op(3, 24'h00_0000, 8'h00, 1'b0);
        op(0, 24'h00_0000, 8'h00, 1'b1);
        op(1, 24'h00_0000, 8'h00, 1'b1);
        check(statusReg[1], 1'b0);
        op(4, 24'h00_0000, 8'h00, 1'b0);
        // Every protect code against every block and a full erase
        for (int c = 0; c < 16; c++) begin
            setStatus({2'b00, c[3:0], 2'b00});
            m = maskOf(c[3:0]);
            for (int b = 0; b < 4; b++) begin
                op(0, 24'h00_0000, 8'h00, 1'b1);
                op(3 + b[0], {6'h00, b[1:0], 16'h0000}, 8'h00, !m[b]);
                waitIdle();
                check(statusReg[1], m[b]);
            end
            op(0, 24'h00_0000, 8'h00, 1'b1);
            op(5, 24'h00_0000, 8'h00, c == 0);
            waitIdle();
        end
        // Suspend and resume of a slow program, then of an erase
        setStatus(8'h00);
        doneDelay = 8'h28;
        for (int k = 3; k < 5; k++) begin
            op(0, 24'h00_0000, 8'h00, 1'b1);
            op(k, 24'h01_0000, 8'h00, 1'b1);
            check(arrayAddr, 24'h01_0000);
            check(arrayOp, 24'(k - 3));
            cmdSuspend = 1'b1;
            tick();
            cmdSuspend = 1'b0;
            tick();
            check({arrayPause, suspendState}, (k == 3) ? 9'h104 : 9'h102);
            op(0, 24'h00_0000, 8'h00, 1'b1);
            op(3, 24'h02_0000, 8'h00, 1'b0);
            cmdResume = 1'b1;
            tick();
            cmdResume = 1'b0;
            tick();
            check(suspendState, 8'h00);
            waitIdle();
        end
        // Disable bit against protect pin level, all four rows
        for (int r = 0; r < 4; r++) begin
            pin2Drv = 1'b1;
            tick(3);
            setStatus({r[1], 7'h00});
            pin2Drv = r[0];
            tick(3);
            op(0, 24'h00_0000, 8'h00, 1'b1);
            op(2, 24'h00_0000, 8'h08, !(r[1] && !r[0]));
            waitIdle();
            check(statusReg[7:2], (r[1] && !r[0]) ? 6'h20 : 6'h02);
        end
        pin2Drv = 1'b1;
        tick(3);
        setStatus(8'h40);
        check(quadMode, 1'b1);
        // Pins stay driven, never tied high, while quad is set
        quadDrive = 1'b1;
        quadDataOut = 2'b10;
        pin2Drv = 1'b0;
        pin3Drv = 1'b0;
        tick(3);
        check({dataLine2OeN, dataLine3OeN, quadDataIn, serialPaused}, 5'b00100);
        quadDrive = 1'b0;
        tick(3);
        check({dataLine2OeN, dataLine3OeN, quadDataIn, serialPaused}, 5'b11000);
        pin2Drv = 1'b1;
        setStatus(8'h00);
        tick(3);
        check({quadMode, serialPaused}, 2'b01);
        pin3Drv = 1'b1;
        tick(3);
        check(serialPaused, 1'b0);
        finishTest();
    end
endmodule
